//--- bench/sac_afe_model.sv
// behavioural analog front end: channel mux, sample-and-hold and comparator
`timescale 1ns/1ps
module sac_afe_model
(
   // clock
   input  wire logic        mclk,
   // controller side
   input  wire logic        sample_hold_q,
   input  wire logic [9:0]  dac_code_q,
   input  wire logic [2:0]  channel_sel_q,
   // ten-bit level of each of the eight inputs
   input  wire logic [79:0] levels,
   // comparator output
   output logic             comp_in
);
   logic [9:0] held_q;

   // follow the selected input while sampling, freeze it in hold
   always_ff @(posedge mclk)
   begin
      if (sample_hold_q)
         held_q <= levels[channel_sel_q*10 +: 10];
   end

   // comparator: held input at or above the tap
   assign comp_in = (held_q >= dac_code_q);
endmodule : sac_afe_model

//--- bench/test_sar_adc_controller.sv
// self-checking bench for the converter controller
`timescale 1ns/1ps
module test_sar_adc_controller
   import sac_pkg::*;
;
   logic        mclk;
   logic        rst_n;
   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata;
   logic        bus_wr;
   logic        bus_bit_wr;
   logic [2:0]  bus_bit_pos;
   logic        bus_rd;
   logic [15:0] bus_rdata_q;
   logic        comp_in;
   logic        hw_trigger_pin;
   logic        sample_hold_q;
   logic [9:0]  dac_code_q;
   logic [2:0]  channel_sel_q;
   logic [7:0]  digital_in_en_q;
   logic        ref_generator_enable_q;
   logic        conv_active_q;
   logic        conversion_done_irq_q;
   logic [79:0] levels;
   logic [2:0]  ct_tab [6];
   int          len_tab [6];
   int          edge_exp [4];
   int          err_count;
   int          tests_run;
   int          cycles;
   int          irq_cnt;
   int          seed;
   int          n;
   int          k;
   int          chn;
   int          lva;
   int          lvb;

   sac_ctrl uut
   (
      .mclk                   (mclk),
      .rst_n                  (rst_n),
      .bus_addr               (bus_addr),
      .bus_wdata              (bus_wdata),
      .bus_wr                 (bus_wr),
      .bus_bit_wr             (bus_bit_wr),
      .bus_bit_pos            (bus_bit_pos),
      .bus_rd                 (bus_rd),
      .bus_rdata_q            (bus_rdata_q),
      .comp_in                (comp_in),
      .hw_trigger_pin         (hw_trigger_pin),
      .sample_hold_q          (sample_hold_q),
      .dac_code_q             (dac_code_q),
      .channel_sel_q          (channel_sel_q),
      .digital_in_en_q        (digital_in_en_q),
      .ref_generator_enable_q (ref_generator_enable_q),
      .conv_active_q          (conv_active_q),
      .conversion_done_irq_q  (conversion_done_irq_q)
   );

   sac_afe_model afe
   (
      .mclk          (mclk),
      .sample_hold_q (sample_hold_q),
      .dac_code_q    (dac_code_q),
      .channel_sel_q (channel_sel_q),
      .levels        (levels),
      .comp_in       (comp_in)
   );

   // verdict and end of run
   task automatic test_done();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // byte write, or single-bit write when b is set
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] p);
      @(posedge mclk);
      bus_addr    <= a;
      bus_wdata   <= d;
      bus_bit_pos <= p;
      bus_wr      <= ~b;
      bus_bit_wr  <= b;
      @(posedge mclk);
      bus_wr      <= 1'b0;
      bus_bit_wr  <= 1'b0;
   endtask : wr

   // read, data checked in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge mclk);
      bus_rd   <= 1'b0;
      #1;
      chk(bus_rdata_q, exp);
   endtask : rd

   // count edges until the done pulse, bounded
   task automatic wait_irq(output int cnt);
      cnt = 0;
      do
      begin
         @(posedge mclk);
         #1;
         cnt++;
      end
      while (conversion_done_irq_q !== 1'b1 && cnt < 400);
   endtask : wait_irq

   // clock
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // done pulse counter and hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (conversion_done_irq_q === 1'b1)
         irq_cnt++;
      if (cycles == 20000)
      begin
         err_count++;
         test_done();
      end
   end

   // main sequence
   initial
   begin
      rst_n = 1'b0;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_bit_wr = 1'b0;
      bus_bit_pos = 3'h0;
      bus_rd = 1'b0;
      hw_trigger_pin = 1'b0;
      levels = 80'h0;
      err_count = 0;
      tests_run = 0;
      cycles = 0;
      irq_cnt = 0;
      chn = 0;
      seed = 32'hdbc93d11;
      ct_tab = '{CT_144, CT_120, CT_96, CT_72, CT_60, CT_48};
      len_tab = '{CYC_144, CYC_120, CYC_96, CYC_72, CYC_60, CYC_48};
      edge_exp = '{0, 1, 1, 2};
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk({8'h00, digital_in_en_q}, 16'h00fe);
      rd(ADDR_MODE, 16'h0000);
      rd(ADDR_CHAN, 16'h0000);
      rd(ADDR_RESULT, 16'h0000);
      rd(16'hff82, 16'h0000);
      // reference on before any run, so no result has to be dropped
      wr(ADDR_MODE, 8'h01, 1'b0, 3'h0);
      repeat (3500) @(posedge mclk);
      #1;
      chk({15'h0, ref_generator_enable_q}, 16'h0001);
      // software start at every conversion length
      for (k = 0; k < 6; k++)
      begin
         chn = $random(seed) & 7;
         levels = 80'({$random(seed), $random(seed), $random(seed)});
         lva = int'(levels[chn*10 +: 10]);
         wr(ADDR_CHAN, 8'(chn), 1'b0, 3'h0);
         rd(ADDR_CHAN, 16'(chn));
         chk({13'h0, channel_sel_q}, 16'(chn));
         chk({8'h00, digital_in_en_q}, {8'h00, ~(8'h01 << chn)});
         wr(ADDR_MODE, {2'b10, ct_tab[k], 3'b001}, 1'b0, 3'h0);
         wait_irq(n);
         chk(16'(n), 16'(len_tab[k]));
         rd(ADDR_RESULT, 16'(lva << 6));
         repeat (28) @(posedge mclk);
         #1;
         levels = 80'({$random(seed), $random(seed), $random(seed)});
         lvb = int'(levels[chn*10 +: 10]);
         wait_irq(n);
         chk(16'(n), 16'(len_tab[k] - 30));
         rd(ADDR_RESULT, 16'(lva << 6));
         wait_irq(n);
         chk(16'(n), 16'(len_tab[k] - 2));
         rd(ADDR_RESULT, 16'(lvb << 6));
         wr(ADDR_MODE, 8'h01, 1'b0, 3'h0);
         repeat (2) @(posedge mclk);
         #1;
         chk({15'h0, conv_active_q}, 16'h0000);
         n = irq_cnt;
         repeat (200) @(posedge mclk);
         #1;
         chk(16'(irq_cnt - n), 16'h0000);
      end
      // a register write in mid-conversion restarts it
      wr(ADDR_MODE, {2'b10, CT_48, 3'b001}, 1'b0, 3'h0);
      repeat (20) @(posedge mclk);
      wr(ADDR_CHAN, 8'(chn), 1'b0, 3'h0);
      wait_irq(n);
      chk(16'(n), 16'(CYC_48));
      rd(ADDR_RESULT, 16'(lvb << 6));
      wr(ADDR_MODE, 8'h01, 1'b0, 3'h0);
      // trigger start with every edge selection, run set by bit write
      for (k = 0; k < 4; k++)
      begin
         wr(ADDR_MODE, {2'b01, CT_48, 2'(k), 1'b1}, 1'b0, 3'h0);
         wr(ADDR_MODE, 8'h01, 1'b1, 3'h7);
         rd(ADDR_MODE, {8'h00, 2'b11, CT_48, 2'(k), 1'b1});
         n = irq_cnt;
         @(posedge mclk);
         hw_trigger_pin <= 1'b1;
         repeat (100) @(posedge mclk);
         hw_trigger_pin <= 1'b0;
         repeat (100) @(posedge mclk);
         #1;
         chk(16'(irq_cnt - n), 16'(edge_exp[k]));
         rd(ADDR_RESULT, 16'(lvb << 6));
         wr(ADDR_MODE, 8'h00, 1'b1, 3'h7);
      end
      wr(ADDR_MODE, 8'h00, 1'b0, 3'h0);
      repeat (2) @(posedge mclk);
      #1;
      chk({15'h0, ref_generator_enable_q}, 16'h0000);
      test_done();
   end
endmodule : test_sar_adc_controller

//--- common/sac_pkg.sv
// package: register map, field layout and timing of the converter controller
package sac_pkg;

   // register byte addresses
   localparam logic [15:0] ADDR_MODE   = 16'hff80;
   localparam logic [15:0] ADDR_CHAN   = 16'hff81;
   localparam logic [15:0] ADDR_RESULT = 16'hff16;

   // reset values
   localparam logic [7:0]  MODE_RST   = 8'h00;
   localparam logic [2:0]  CHAN_RST   = 3'h0;
   localparam logic [15:0] RESULT_RST = 16'h0000;

   // converter_mode_control field positions
   localparam int RUN_BIT       = 7;
   localparam int START_SRC_BIT = 6;
   localparam int CONV_TIME_HI  = 5;
   localparam int CONV_TIME_LO  = 3;
   localparam int TRIG_EDGE_HI  = 2;
   localparam int TRIG_EDGE_LO  = 1;
   localparam int REF_GEN_BIT   = 0;

   // result layout: ten bits on top, six zero bits below
   localparam int SAR_WIDTH = 10;
   localparam int RES_PAD   = 6;

   // conversion time codes
   localparam logic [2:0] CT_144 = 3'h0;
   localparam logic [2:0] CT_120 = 3'h1;
   localparam logic [2:0] CT_96  = 3'h2;
   localparam logic [2:0] CT_72  = 3'h4;
   localparam logic [2:0] CT_60  = 3'h5;
   localparam logic [2:0] CT_48  = 3'h6;

   // trigger edge codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // a conversion is two sample steps then one step per result bit
   localparam int SAMPLE_STEPS = 2;
   localparam int CONV_STEPS   = SAMPLE_STEPS + SAR_WIDTH;
   localparam logic [3:0] LAST_STEP = 4'(CONV_STEPS - 1);

   // conversion lengths in main clock cycles and the step length of each
   localparam int CYC_144 = 144;
   localparam int CYC_120 = 120;
   localparam int CYC_96  = 96;
   localparam int CYC_72  = 72;
   localparam int CYC_60  = 60;
   localparam int CYC_48  = 48;
   localparam logic [3:0] STEP_144 = 4'(CYC_144 / CONV_STEPS);
   localparam logic [3:0] STEP_120 = 4'(CYC_120 / CONV_STEPS);
   localparam logic [3:0] STEP_96  = 4'(CYC_96 / CONV_STEPS);
   localparam logic [3:0] STEP_72  = 4'(CYC_72 / CONV_STEPS);
   localparam logic [3:0] STEP_60  = 4'(CYC_60 / CONV_STEPS);
   localparam logic [3:0] STEP_48  = 4'(CYC_48 / CONV_STEPS);

   // sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_CONV} sac_state_type;

endpackage : sac_pkg

//--- rtl/sac_ctrl.sv
// converter controller top: registers, sequencer, result and request
`timescale 1ns/1ps
module sac_ctrl
   import sac_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_bit_wr,
   input  wire logic [2:0]  bus_bit_pos,
   input  wire logic        bus_rd,
   output logic      [15:0] bus_rdata_q,
   // analog front end
   input  wire logic        comp_in,
   input  wire logic        hw_trigger_pin,
   output logic             sample_hold_q,
   output logic      [9:0]  dac_code_q,
   output logic      [2:0]  channel_sel_q,
   output logic      [7:0]  digital_in_en_q,
   output logic             ref_generator_enable_q,
   output logic             conv_active_q,
   // conversion end request
   output logic             conversion_done_irq_q
);

   sac_state_type state_q;
   sac_state_type state_d;
   logic [7:0]  mode_q;
   logic [7:0]  mode_d;
   logic [7:0]  mode_bit;
   logic [2:0]  chan_q;
   logic [2:0]  chan_d;
   logic [15:0] result_q;
   logic [15:0] result_d;
   logic [15:0] rdata_d;
   logic [3:0]  cyc_q;
   logic [3:0]  cyc_d;
   logic [3:0]  step_q;
   logic [3:0]  step_d;
   logic [3:0]  step_len;
   logic [3:0]  bit_idx;
   logic [9:0]  sar_q;
   logic        mode_wr;
   logic        chan_wr;
   logic        reg_wr;
   logic        run_d;
   logic        hw_d;
   logic        trig_hit;
   logic        step_end;
   logic        start_go;
   logic        trial;
   logic        decide;
   logic        last_decide;

   // register write decode
   assign mode_wr  = (bus_wr || bus_bit_wr) && bus_addr == ADDR_MODE;
   assign chan_wr  = bus_wr && bus_addr == ADDR_CHAN;
   assign reg_wr   = mode_wr || chan_wr;
   assign mode_bit = (mode_q & ~(8'h01 << bus_bit_pos)) | ({7'h00, bus_wdata[0]} << bus_bit_pos);
   assign mode_d   = !mode_wr ? mode_q : (bus_bit_wr ? mode_bit : bus_wdata);
   assign chan_d   = chan_wr ? bus_wdata[2:0] : chan_q;
   assign run_d    = mode_d[RUN_BIT];
   assign hw_d     = mode_d[START_SRC_BIT];

   // step length from the conversion time field; prohibited codes use the longest
   assign step_len = (mode_q[CONV_TIME_HI:CONV_TIME_LO] == CT_120) ? STEP_120 :
                     (mode_q[CONV_TIME_HI:CONV_TIME_LO] == CT_96)  ? STEP_96  :
                     (mode_q[CONV_TIME_HI:CONV_TIME_LO] == CT_72)  ? STEP_72  :
                     (mode_q[CONV_TIME_HI:CONV_TIME_LO] == CT_60)  ? STEP_60  :
                     (mode_q[CONV_TIME_HI:CONV_TIME_LO] == CT_48)  ? STEP_48  :
                     STEP_144;

   // step pacing and successive approximation strobes
   assign step_end    = cyc_q == step_len - 4'h1;
   assign bit_idx     = LAST_STEP - step_q;
   assign trial       = state_q == ST_CONV && cyc_q == 4'h0;
   assign decide      = state_q == ST_CONV && step_end;
   assign last_decide = decide && step_q == LAST_STEP;
   assign result_d    = {sar_q[9:1], comp_in, {RES_PAD{1'b0}}};

   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      if (!run_d)
         state_d = ST_IDLE;
      else if (reg_wr)
         state_d = hw_d ? ST_WAIT : ST_SAMPLE;
      else
      begin
         unique case (state_q)
            ST_IDLE:   state_d = hw_d ? ST_WAIT : ST_SAMPLE;
            ST_WAIT:   state_d = trig_hit ? ST_SAMPLE : ST_WAIT;
            ST_SAMPLE: state_d = (step_end && step_q == 4'(SAMPLE_STEPS - 1)) ? ST_CONV : ST_SAMPLE;
            ST_CONV:
            begin
               if (last_decide)
                  state_d = hw_d ? ST_WAIT : ST_SAMPLE;
            end
         endcase
      end
   end

   // counters restart whenever a fresh sample phase begins
   assign start_go = state_d == ST_SAMPLE && (state_q != ST_SAMPLE || reg_wr);
   assign cyc_d    = (start_go || step_end) ? 4'h0 : cyc_q + 4'h1;
   assign step_d   = start_go ? 4'h0 : (step_end ? step_q + 4'h1 : step_q);

   // register read mux; unmapped addresses read zero
   assign rdata_d = !bus_rd                 ? 16'h0000 :
                    bus_addr == ADDR_MODE   ? {8'h00, mode_q} :
                    bus_addr == ADDR_CHAN   ? {13'h0000, chan_q} :
                    bus_addr == ADDR_RESULT ? result_q : 16'h0000;

   // trigger edge detection
   sac_trig_edge u_trig (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pin      (hw_trigger_pin),
      .edge_sel (mode_q[TRIG_EDGE_HI:TRIG_EDGE_LO]),
      .hit_q    (trig_hit)
   );

   // approximation register, cleared through the sample phase
   sac_sar u_sar (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .clr     (state_q == ST_SAMPLE),
      .trial   (trial),
      .decide  (decide),
      .bit_idx (bit_idx),
      .comp_in (comp_in),
      .sar_q   (sar_q)
   );

   // software registers and sequencer state
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q  <= MODE_RST;
         chan_q  <= CHAN_RST;
         state_q <= ST_IDLE;
         cyc_q   <= 4'h0;
         step_q  <= 4'h0;
      end
      else
      begin
         mode_q  <= mode_d;
         chan_q  <= chan_d;
         state_q <= state_d;
         cyc_q   <= cyc_d;
         step_q  <= step_d;
      end
   end

   // result and request
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_q              <= RESULT_RST;
         conversion_done_irq_q <= 1'b0;
      end
      else
      begin
         if (last_decide && !reg_wr && run_d)
            result_q <= result_d;
         conversion_done_irq_q <= last_decide && !reg_wr && run_d;
      end
   end

   // pin side outputs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sample_hold_q          <= 1'b0;
         dac_code_q             <= 10'h000;
         channel_sel_q          <= 3'h0;
         digital_in_en_q        <= 8'hfe;
         ref_generator_enable_q <= 1'b0;
         conv_active_q          <= 1'b0;
         bus_rdata_q            <= 16'h0000;
      end
      else
      begin
         sample_hold_q          <= state_d == ST_SAMPLE;
         dac_code_q             <= sar_q;
         channel_sel_q          <= chan_d;
         digital_in_en_q        <= ~(8'h01 << chan_d);
         ref_generator_enable_q <= mode_d[REF_GEN_BIT];
         conv_active_q          <= state_d == ST_SAMPLE || state_d == ST_CONV;
         bus_rdata_q            <= rdata_d;
      end
   end

   // helper: cycles since the sample phase began, for checking length
   logic [7:0] len_q;
   logic [7:0] len_exp;
   assign len_exp = 8'(step_len) * 8'(CONV_STEPS);   // widen before the product, 12 x 12 fits
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         len_q <= 8'h00;
      else
         len_q <= start_go ? 8'h00 : len_q + 8'h01;
   end

   // sample phase followed by hold in the next cycle
   sequence s_sample_then_hold;
      sample_hold_q ##1 !sample_hold_q;
   endsequence

   AST_HOLD_IN_CONV: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == ST_CONV |-> !sample_hold_q)
      else $error("sample switch closed during comparison");

   AST_SAMPLE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_q == ST_SAMPLE && state_d == ST_CONV) |-> s_sample_then_hold)
      else $error("sample phase not followed by hold");

   AST_MSB_FIRST: assert property (@(posedge mclk) disable iff (!rst_n)
      (trial && step_q == 4'(SAMPLE_STEPS) && run_d && !reg_wr) |=> sar_q == 10'h200)
      else $error("first trial is not the top bit");

   AST_RESULT_COPY: assert property (@(posedge mclk) disable iff (!rst_n)
      (last_decide && !reg_wr && run_d) |=> result_q == $past(result_d))
      else $error("result not copied at the last bit");

   AST_LOW_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      result_q[5:0] == 6'h00)
      else $error("result low bits not zero");

   AST_DONE_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
      conversion_done_irq_q |-> $past(len_q) == len_exp - 8'h01)
      else $error("conversion length wrong");

   AST_RUN_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
      (!run_d) |=> !conv_active_q ##1 !conversion_done_irq_q)
      else $error("conversion continued after run cleared");

   AST_HW_ONE_SHOT: assert property (@(posedge mclk) disable iff (!rst_n)
      (last_decide && hw_d && run_d && !reg_wr) |=> state_q == ST_WAIT
         ##1 (state_q == ST_WAIT || $past(trig_hit || !run_d || reg_wr)))
      else $error("trigger mode converted without a new edge");

   AST_ABORT_RESTART: assert property (@(posedge mclk) disable iff (!rst_n)
      (reg_wr && run_d && !hw_d) |=> (state_q == ST_SAMPLE && step_q == 4'h0 && cyc_q == 4'h0))
      else $error("write did not restart conversion");

   AST_CHAN_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
      digital_in_en_q == ~(8'h01 << channel_sel_q))
      else $error("digital input enable not tied to channel");

endmodule : sac_ctrl

//--- rtl/sac_sar.sv
// successive approximation register, one flop per result bit
`timescale 1ns/1ps
module sac_sar
   import sac_pkg::*;
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // sequencing strobes
   input  wire logic                 clr,
   input  wire logic                 trial,
   input  wire logic                 decide,
   input  wire logic [3:0]           bit_idx,
   // comparator: input at or above tap
   input  wire logic                 comp_in,
   // trial code to the resistor string tap
   output logic [SAR_WIDTH-1:0]      sar_q
);

   // each bit is set on trial and kept or dropped on decide
   for (genvar i = 0; i < SAR_WIDTH; i++)
   begin : g_bit
      always_ff @(posedge mclk or negedge rst_n)
      begin
         if (!rst_n)
            sar_q[i] <= 1'b0;
         else if (clr)
            sar_q[i] <= 1'b0;
         else if (trial && bit_idx == 4'(i))
            sar_q[i] <= 1'b1;
         else if (decide && bit_idx == 4'(i))
            sar_q[i] <= comp_in;
      end
   end

endmodule : sac_sar

//--- rtl/sac_trig_edge.sv
// trigger pin edge detector with selectable edge
`timescale 1ns/1ps
module sac_trig_edge
   import sac_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // trigger pin and edge selection
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   // one-cycle valid edge
   output logic            hit_q
);

   logic pin_q;
   logic rise;
   logic fall;
   logic hit_d;

   // edge qualification against the selected polarity
   assign rise  = pin & ~pin_q;
   assign fall  = ~pin & pin_q;
   assign hit_d = (edge_sel == EDGE_FALL) ? fall :
                  (edge_sel == EDGE_RISE) ? rise :
                  (edge_sel == EDGE_BOTH) ? (rise | fall) : 1'b0;

   // previous level and registered hit
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_q <= 1'b0;
         hit_q <= 1'b0;
      end
      else
      begin
         pin_q <= pin;
         hit_q <= hit_d;
      end
   end

endmodule : sac_trig_edge
